// ===== srt_timer.sv
// Split reload timer: one 16-bit or two 8-bit auto-reload timers plus external oscillator capture.
// Assumes all control ports and write strobes are synchronous to clk_sys; the oscillator
// divided by 8 arrives asynchronously and is retimed here before any use.
`timescale 1ns/1ps

module srt_timer
  import srt_pkg::*;
(
  input  wire logic       clk_sys,                // System clock, 10 MHz
  input  wire logic       sys_rst,                // Synchronous reset, active high
  input  wire logic       ext_osc_div8,           // External oscillator divided by 8, asynchronous
  input  wire logic       split_mode_select,      // Two 8-bit timers when high
  input  wire logic       run_control,            // Run bit
  input  wire logic       low_byte_irq_enable,    // Low byte interrupt enable
  input  wire logic       capture_enable,         // Oscillator capture mode
  input  wire logic       external_clock_select,  // Oscillator/8 instead of system/12
  input  wire logic       high_half_clock_select, // High half runs on system clock
  input  wire logic       low_half_clock_select,  // Low half runs on system clock
  input  wire logic       timer_irq_enable,       // Timer interrupt enable
  input  wire logic [7:0] wr_data,                // Write data for the byte strobes
  input  wire logic       count_low_wr,           // Write strobe, count low byte
  input  wire logic       count_high_wr,          // Write strobe, count high byte
  input  wire logic       reload_low_wr,          // Write strobe, reload low byte
  input  wire logic       reload_high_wr,         // Write strobe, reload high byte
  input  wire logic       high_flag_clear,        // Clear pulse for the high flag
  input  wire logic       low_flag_clear,         // Clear pulse for the low flag
  output logic      [7:0] count_low_byte,         // Count low byte
  output logic      [7:0] count_high_byte,        // Count high byte
  output logic      [7:0] reload_low_byte,        // Reload or capture low byte
  output logic      [7:0] reload_high_byte,       // Reload or capture high byte
  output logic            high_overflow_flag,     // Sticky high overflow flag
  output logic            low_overflow_flag,      // Sticky low overflow flag
  output logic            timer_irq               // Interrupt request level
);

  logic [3:0]  psc_reg;
  logic        div12_tick;
  logic        osc_sync1_reg;
  logic        osc_sync2_reg;
  logic        osc_last_reg;
  logic        osc_rise;
  logic        osc_fall;
  logic        tick_lo;
  logic        tick_hi;
  logic        tick_16;
  logic [7:0]  cnt_lo_reg;
  logic [7:0]  cnt_hi_reg;
  logic [7:0]  cnt_lo_next;
  logic [7:0]  cnt_hi_next;
  logic [7:0]  rld_lo_reg;
  logic [7:0]  rld_hi_reg;
  logic [15:0] count_full;
  logic [15:0] reload_full;
  logic [15:0] sum_full;
  logic        lo_wrap;
  logic        hi_wrap;
  logic        capture_evt;
  logic        hf_reg;
  logic        lf_reg;
  logic        sw_idle;

  // Clock pick of one half: system clock, else the external select chooses the slow source
  function automatic logic clk_pick(input logic sys_sel, input logic ext_sel,
                                    input logic t_div12, input logic t_osc);
    clk_pick = sys_sel ? 1'b1 : (ext_sel ? t_osc : t_div12);
  endfunction : clk_pick

  // Free-running prescaler for the divide-by-12 tick
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      psc_reg <= SRT_PSC_ZERO;
    end else if (psc_reg == SRT_PSC_LAST) begin
      psc_reg <= SRT_PSC_ZERO;
    end else begin
      psc_reg <= psc_reg + SRT_PSC_STEP;
    end
  end

  assign div12_tick = (psc_reg == SRT_PSC_LAST);

  // Two-flop retiming; the edge detector looks only at the second stage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      osc_sync1_reg <= 1'b0;
      osc_sync2_reg <= 1'b0;
      osc_last_reg  <= 1'b0;
    end else begin
      osc_sync1_reg <= ext_osc_div8;
      osc_sync2_reg <= osc_sync1_reg;
      osc_last_reg  <= osc_sync2_reg;
    end
  end

  assign osc_rise    = osc_sync2_reg & ~osc_last_reg;
  assign osc_fall    = ~osc_sync2_reg & osc_last_reg;
  assign capture_evt = capture_enable & osc_fall;

  assign tick_lo = clk_pick(low_half_clock_select, external_clock_select, div12_tick, osc_rise);
  assign tick_hi = clk_pick(high_half_clock_select, external_clock_select, div12_tick, osc_rise);
  // Capture mode cannot count the clock it measures, so in capture mode the 16-bit count runs on system clock or system/12, never the oscillator
  assign tick_16 = capture_enable ? (low_half_clock_select | div12_tick) : tick_lo;

  assign count_full  = {cnt_hi_reg, cnt_lo_reg};
  assign reload_full = {rld_hi_reg, rld_lo_reg};
  assign sum_full    = count_full + SRT_WORD_STEP;
  assign sw_idle     = ~(count_low_wr | count_high_wr);

  always_comb begin
    cnt_lo_next = cnt_lo_reg;
    cnt_hi_next = cnt_hi_reg;
    lo_wrap     = 1'b0;
    hi_wrap     = 1'b0;
    if (split_mode_select) begin
      if (tick_lo) begin
        if (cnt_lo_reg == SRT_BYTE_MAX) begin
          lo_wrap     = 1'b1;
          cnt_lo_next = rld_lo_reg;
        end else begin
          cnt_lo_next = cnt_lo_reg + SRT_BYTE_STEP;
        end
      end
      if (run_control && tick_hi) begin
        if (cnt_hi_reg == SRT_BYTE_MAX) begin
          hi_wrap     = 1'b1;
          cnt_hi_next = rld_hi_reg;
        end else begin
          cnt_hi_next = cnt_hi_reg + SRT_BYTE_STEP;
        end
      end
    end else if (run_control && tick_16) begin
      lo_wrap = (cnt_lo_reg == SRT_BYTE_MAX);
      if (count_full == SRT_WORD_MAX) begin
        // Reload bytes hold captures in capture mode, so the count wraps to zero instead
        hi_wrap = ~capture_enable;
        {cnt_hi_next, cnt_lo_next} = capture_enable ? SRT_WORD_ZERO : reload_full;
      end else begin
        {cnt_hi_next, cnt_lo_next} = sum_full;
      end
    end
    if (count_low_wr) begin
      cnt_lo_next = wr_data;
    end
    if (count_high_wr) begin
      cnt_hi_next = wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cnt_lo_reg <= SRT_BYTE_ZERO;
      cnt_hi_reg <= SRT_BYTE_ZERO;
    end else begin
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
    end
  end

  // Capture outranks a software reload write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rld_lo_reg <= SRT_BYTE_ZERO;
      rld_hi_reg <= SRT_BYTE_ZERO;
    end else if (capture_evt) begin
      rld_lo_reg <= cnt_lo_reg;
      rld_hi_reg <= cnt_hi_reg;
    end else begin
      if (reload_low_wr) begin
        rld_lo_reg <= wr_data;
      end
      if (reload_high_wr) begin
        rld_hi_reg <= wr_data;
      end
    end
  end

  // Flags: an event in the clearing cycle still sets the flag
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      hf_reg <= SRT_FLAG_RESET;
      lf_reg <= SRT_FLAG_RESET;
    end else begin
      if (hi_wrap || capture_evt) begin
        hf_reg <= 1'b1;
      end else if (high_flag_clear) begin
        hf_reg <= 1'b0;
      end
      if (lo_wrap) begin
        lf_reg <= 1'b1;
      end else if (low_flag_clear) begin
        lf_reg <= 1'b0;
      end
    end
  end

  assign count_low_byte     = cnt_lo_reg;
  assign count_high_byte    = cnt_hi_reg;
  assign reload_low_byte    = rld_lo_reg;
  assign reload_high_byte   = rld_hi_reg;
  assign high_overflow_flag = hf_reg;
  assign low_overflow_flag  = lf_reg;
  // Same equation serves both modes; the low flag only counts while its enable is set
  assign timer_irq = timer_irq_enable & (hf_reg | (low_byte_irq_enable & lf_reg));

  wrap16_reload_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!split_mode_select && !capture_enable && run_control && tick_16 && sw_idle
      && count_full == SRT_WORD_MAX)
    |=> (count_full == $past(reload_full)) && hf_reg)
    else $error("16-bit wrap did not reload or set the high flag");

  run_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!split_mode_select && !run_control && sw_idle && !capture_evt)
    |=> $stable(count_full))
    else $error("16-bit count moved while stopped");

  low_free_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (split_mode_select && !run_control && tick_lo && !count_low_wr && cnt_lo_reg != SRT_BYTE_MAX)
    |=> (cnt_lo_reg == $past(cnt_lo_reg) + SRT_BYTE_STEP)
      && ($stable(cnt_hi_reg) || $past(count_high_wr)))
    else $error("Split low half not free running");

  high_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (split_mode_select && run_control && tick_hi && !count_high_wr && cnt_hi_reg == SRT_BYTE_MAX)
    |=> (cnt_hi_reg == $past(rld_hi_reg)) && hf_reg)
    else $error("Split high half wrap wrong");

  low_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (split_mode_select && tick_lo && !count_low_wr && !count_high_wr && cnt_lo_reg == SRT_BYTE_MAX
      && !(run_control && tick_hi))
    |=> (cnt_lo_reg == $past(rld_lo_reg)) && lf_reg && $stable(cnt_hi_reg))
    else $error("Split low half wrap wrong");

  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (hf_reg && !high_flag_clear) |=> hf_reg)
    else $error("High flag cleared by hardware");

  capture_copy_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    capture_evt |=> (reload_full == $past(count_full)) && hf_reg)
    else $error("Capture did not copy the count");

  capture_edge_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (capture_enable && $fell(osc_sync2_reg)) |-> capture_evt)
    else $error("Falling edge gave no capture");

  osc_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    osc_rise |-> $past(ext_osc_div8, 2) && !$past(ext_osc_div8, 3))
    else $error("Oscillator edge not retimed by two stages");

  div12_period_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    div12_tick |=> !div12_tick [*8] ##1 !div12_tick [*3] ##1 div12_tick)
    else $error("Prescaler period is not twelve");

  sys_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!split_mode_select && capture_enable && low_half_clock_select && run_control && sw_idle
      && count_full != SRT_WORD_MAX)
    |=> count_full == $past(sum_full))
    else $error("Capture mode missed a system clock count");

  irq_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (lo_wrap && timer_irq_enable && low_byte_irq_enable) |=> timer_irq)
    else $error("Low wrap gave no interrupt");

  irq_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (hi_wrap && timer_irq_enable) |=> timer_irq)
    else $error("High overflow gave no interrupt");

  irq_split_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (split_mode_select && timer_irq_enable && !low_byte_irq_enable && lf_reg && !hf_reg) |-> !timer_irq)
    else $error("Low flag interrupted without its enable");

  flag_low_sticky_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (lf_reg && !low_flag_clear) |=> lf_reg)
    else $error("Low flag cleared by hardware");

  flag_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (high_flag_clear && !hi_wrap && !capture_evt) |=> !hf_reg)
    else $error("High flag ignored its clear");

  split_low_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (split_mode_select && lo_wrap) |=> lf_reg)
    else $error("Split low wrap left its flag clear");

  high_run_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (split_mode_select && !run_control && !count_high_wr) |=> $stable(cnt_hi_reg))
    else $error("Split high half moved while stopped");

  count_low_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    count_low_wr |=> (cnt_lo_reg == $past(wr_data)))
    else $error("Count low write lost");

  count_high_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    count_high_wr |=> (cnt_hi_reg == $past(wr_data)))
    else $error("Count high write lost");

  reload_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (reload_low_wr && !capture_evt) |=> (rld_lo_reg == $past(wr_data)))
    else $error("Reload low write lost");

  div12_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!split_mode_select && !capture_enable && !low_half_clock_select && !external_clock_select
      && sw_idle && !div12_tick) |=> $stable(count_full))
    else $error("Count moved between prescaler ticks");

  osc_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!split_mode_select && !capture_enable && !low_half_clock_select && external_clock_select
      && sw_idle && !osc_rise) |=> $stable(count_full))
    else $error("Count moved without an oscillator edge");

  capture_wrap_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!split_mode_select && capture_enable && run_control && tick_16 && sw_idle
      && count_full == SRT_WORD_MAX) |=> (count_full == SRT_WORD_ZERO))
    else $error("Capture mode count did not wrap to zero");

  mode16_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!split_mode_select && run_control && tick_16 && sw_idle && count_full != SRT_WORD_MAX)
    |=> (count_full == $past(sum_full)))
    else $error("16-bit count did not step by one");

  irq_mask_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !timer_irq_enable |-> !timer_irq)
    else $error("Interrupt raised while disabled");

endmodule : srt_timer

// ===== srt_pkg.sv
// Constants shared by the split reload timer with oscillator capture.
// Assumes a single system clock domain; the oscillator input is retimed inside the timer.
package srt_pkg;
  localparam logic [7:0]  SRT_BYTE_MAX    = 8'hFF;           // Last count of an 8-bit half
  localparam logic [7:0]  SRT_BYTE_ZERO   = 8'h00;           // Reset value of every byte
  localparam logic [7:0]  SRT_BYTE_STEP   = 8'h01;           // Increment of an 8-bit half
  localparam logic [15:0] SRT_WORD_MAX    = 16'hFFFF;        // Last count of the 16-bit timer
  localparam logic [15:0] SRT_WORD_ZERO   = 16'h0000;        // Wrap value in capture mode
  localparam logic [15:0] SRT_WORD_STEP   = 16'h0001;        // Increment of the 16-bit timer
  localparam int          SRT_SYS_DIV     = 12;              // System clock prescale ratio
  localparam logic [3:0]  SRT_PSC_ZERO    = 4'h0;            // Prescaler start value
  localparam logic [3:0]  SRT_PSC_STEP    = 4'h1;            // Prescaler increment
  localparam logic [3:0]  SRT_PSC_LAST    = 4'(SRT_SYS_DIV - 1); // Prescaler terminal count
  localparam logic        SRT_FLAG_RESET  = 1'b0;            // Reset value of both flags
endpackage : srt_pkg

// ===== srt_osc_model.sv
// Model of the external oscillator divided by 8, as seen at the timer's pin.
// Assumes the bench enables it at a clock edge; the 37 ns start offset keeps its
// edges away from clk_sys edges, at a fixed phase to the system clock.
`timescale 1ns/1ps

module srt_osc_model (
  input  wire logic enable,   // Oscillator runs while high
  input  wire logic [31:0] half_ns,  // Half period in ns
  output logic      osc_out   // Oscillator divided by 8
);
  initial osc_out = 1'b0;

  // Stands still low between runs; a free-running clock would hide a missing gate
  always @(posedge enable) begin
    #37;
    while (enable) begin
      #(half_ns) osc_out = ~osc_out;
    end
    osc_out = 1'b0;
  end
endmodule : srt_osc_model

// ===== testbench.sv
// Self-checking bench for the split reload timer: modes, reloads, flags, prescale and capture.
// Assumes the oscillator model drives ext_osc_div8; every other input is driven from here.
`timescale 1ns/1ps

module testbench
  import srt_pkg::*;
;
  logic       clk_sys = 1'b0, sys_rst = 1'b1, split = 1'b0, run = 1'b0, lie = 1'b0, cap = 1'b0;
  logic       xsel = 1'b0, hsel = 1'b0, lsel = 1'b1, tie = 1'b1, hclr = 1'b0, lclr = 1'b0;
  logic       osc_en = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic [3:0] strb = 4'h0;
  logic [7:0] cl, ch, rl, rh;
  logic       hf, lf, irq, osc;
  logic [15:0] rnd, a, b;
  int         bad_count = 0, num_checks = 0, cyc = 0, half = 400;

  always #50 clk_sys = ~clk_sys;

  srt_timer u_srt_timer (.clk_sys(clk_sys), .sys_rst(sys_rst), .ext_osc_div8(osc),
    .split_mode_select(split), .run_control(run), .low_byte_irq_enable(lie),
    .capture_enable(cap), .external_clock_select(xsel), .high_half_clock_select(hsel),
    .low_half_clock_select(lsel), .timer_irq_enable(tie), .wr_data(wr_data),
    .count_low_wr(strb[0]), .count_high_wr(strb[1]), .reload_low_wr(strb[2]),
    .reload_high_wr(strb[3]), .high_flag_clear(hclr), .low_flag_clear(lclr),
    .count_low_byte(cl), .count_high_byte(ch), .reload_low_byte(rl), .reload_high_byte(rh),
    .high_overflow_flag(hf), .low_overflow_flag(lf), .timer_irq(irq));

  srt_osc_model u_srt_osc_model (.enable(osc_en), .half_ns(half), .osc_out(osc));

  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr_next

  function automatic logic [15:0] exp_next16(input logic [15:0] cnt, input logic [15:0] rld);
    return (cnt == SRT_WORD_MAX) ? rld : cnt + SRT_WORD_STEP;
  endfunction : exp_next16

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // One strobe pulse; 0 count low, 1 count high, 2 reload low, 3 reload high
  task automatic wr_byte(input int which, input logic [7:0] d);
    @(posedge clk_sys);
    wr_data <= d;
    strb    <= 4'(1 << which);
    @(posedge clk_sys);
    strb    <= 4'h0;
  endtask : wr_byte

  // Run bit is sampled high at exactly n edges
  task automatic run_for(input int n);
    @(posedge clk_sys);
    run <= 1'b1;
    repeat (n) @(posedge clk_sys);
    run <= 1'b0;
  endtask : run_for

  task automatic clr_flags();
    @(posedge clk_sys);
    hclr <= 1'b1;
    lclr <= 1'b1;
    @(posedge clk_sys);
    hclr <= 1'b0;
    lclr <= 1'b0;
  endtask : clr_flags

  task automatic wait_hf();
    int n;
    n = 0;
    @(negedge clk_sys);
    while (hf !== 1'b1 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    chk({15'h0000, hf}, 16'h0001, "capture flag missing");
  endtask : wait_hf

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    chk({ch, cl}, 16'h0000, "count reset");
    chk({rh, rl}, 16'h0000, "reload reset");
    chk({13'h0000, hf, lf, irq}, 16'h0000, "flag reset");
    rnd = lfsr_next(16'h546E);
    rnd[15] = 1'b0;
    wr_byte(0, 8'hFE);
    wr_byte(1, 8'hFF);
    wr_byte(2, rnd[7:0]);
    wr_byte(3, rnd[15:8]);
    @(negedge clk_sys);
    chk({ch, cl}, 16'hFFFE, "count write");
    chk({rh, rl}, rnd, "reload write");
    run_for(2);
    @(negedge clk_sys);
    chk({ch, cl}, exp_next16(16'hFFFF, rnd), "16-bit reload");
    chk({14'h0000, hf, irq}, 16'h0003, "16-bit overflow irq");
    run_for(1);
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk({ch, cl}, exp_next16(rnd, rnd), "count held while stopped");
    chk({15'h0000, hf}, 16'h0001, "flag stays set");
    @(posedge clk_sys);
    tie <= 1'b0;
    @(negedge clk_sys);
    chk({15'h0000, irq}, 16'h0000, "irq masked");
    tie <= 1'b1;
    lie <= 1'b1;
    clr_flags();
    @(negedge clk_sys);
    chk({13'h0000, hf, lf, irq}, 16'h0000, "flags cleared");
    wr_byte(0, 8'hFF);
    wr_byte(1, 8'h00);
    run_for(1);
    @(negedge clk_sys);
    chk({ch, cl}, 16'h0100, "low byte carry");
    chk({13'h0000, hf, lf, irq}, 16'h0003, "low byte irq");
    @(posedge clk_sys);
    lie <= 1'b0;
    @(negedge clk_sys);
    chk({15'h0000, irq}, 16'h0000, "low irq disabled");
    // Split mode, both halves on the system clock
    @(posedge clk_sys);
    split <= 1'b1;
    hsel  <= 1'b1;
    lie   <= 1'b1;
    rnd = lfsr_next(rnd);
    clr_flags();
    wr_byte(1, rnd[15:8]);
    wr_byte(2, rnd[7:0]);
    wr_byte(3, ~rnd[7:0]);
    wr_byte(0, 8'hFF);
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({ch, cl}, rnd, "split low reload, high idle");
    chk({13'h0000, hf, lf, irq}, 16'h0003, "split low flag irq");
    @(posedge clk_sys);
    lie <= 1'b0;
    @(negedge clk_sys);
    chk({15'h0000, irq}, 16'h0000, "split low irq off");
    clr_flags();
    wr_byte(1, 8'hFF);
    run_for(1);
    @(negedge clk_sys);
    chk({8'h00, ch}, {8'h00, ~rnd[7:0]}, "split high reload");
    chk({14'h0000, hf, irq}, 16'h0003, "split high flag irq");
    // Divide by 12 in 16-bit mode
    split <= 1'b0;
    hsel  <= 1'b0;
    lsel  <= 1'b0;
    wr_byte(0, 8'h34);
    wr_byte(1, 8'h12);
    run_for(24);
    @(negedge clk_sys);
    chk({ch, cl}, 16'h1236, "divide by 12");
    // Oscillator divided by 8, period of 8 system clocks
    xsel   <= 1'b1;
    osc_en <= 1'b1;
    wr_byte(0, 8'h00);
    wr_byte(1, 8'h00);
    run_for(80);
    @(negedge clk_sys);
    chk({15'h0000, ({ch, cl} >= 16'h0009 && {ch, cl} <= 16'h000B)}, 16'h0001, "osc ticks");
    osc_en <= 1'b0;
    // Capture: system clock count, oscillator period of 16 system clocks
    half = 800;
    repeat (30) @(posedge clk_sys);
    split  <= 1'b0;
    xsel   <= 1'b0;
    lsel   <= 1'b1;
    cap    <= 1'b1;
    run    <= 1'b1;
    osc_en <= 1'b1;
    clr_flags();
    wait_hf();
    a = {rh, rl};
    clr_flags();
    wait_hf();
    b = {rh, rl};
    chk(b - a, 16'h0010, "capture interval");
    close_out();
  end
endmodule : testbench
